// ### src/bale_pkg.sv
/*
 * Shared constants and types of the branch and load execution block.
 * Assumes a single core clock domain and a 16-bit data address space.
 */
package bale_pkg;
    localparam int PC_W = 16;
    localparam int DATA_W = 8;
    localparam int IDX_W = 5;
    localparam int REG_CNT = 32;
    localparam int K_W = 7;
    localparam int Q_W = 6;

    // Status flag bit positions in the flag byte.
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;

    // Low register of each pointer pair.
    localparam logic [IDX_W-1:0] PTR_X_LO = 5'h1a;
    localparam logic [IDX_W-1:0] PTR_Y_LO = 5'h1c;
    localparam logic [IDX_W-1:0] PTR_Z_LO = 5'h1e;

    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_PREDEC = 2'h2;

    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_ABS = 16'h0002;
    localparam logic [PC_W-1:0] PTR_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [PC_W-1:0] RESET_PC = 16'h0000;

    typedef enum logic [3:0] {
        OP_JUMP = 4'h0,
        OP_COPY_REGISTER = 4'h1,
        OP_COPY_REGISTER_PAIR = 4'h2,
        OP_LOAD_CONSTANT = 4'h3,
        OP_LOAD_VIA_POINTER = 4'h4,
        OP_LOAD_POINTER_OFFSET = 4'h5,
        OP_LOAD_ABSOLUTE = 4'h6,
        OP_WRITE_VIA_POINTER = 4'h7
    } bale_op_t;

    // Bits 3:1 pick the tested source, bit 0 set means the source must be zero.
    typedef enum logic [3:0] {
        COND_CARRY_ONE = 4'h0,
        COND_CARRY_ZERO = 4'h1,
        COND_NEGATIVE = 4'h2,
        COND_POSITIVE = 4'h3,
        COND_SIGNED_LESS = 4'h4,
        COND_SIGNED_GE = 4'h5,
        COND_HALF_CARRY_ONE = 4'h6,
        COND_HALF_CARRY_ZERO = 4'h7,
        COND_TRANSFER_ONE = 4'h8,
        COND_TRANSFER_ZERO = 4'h9,
        COND_OVERFLOW_ONE = 4'ha
    } bale_cond_t;

    localparam bale_cond_t COND_LOWER = COND_CARRY_ONE;
    localparam bale_cond_t COND_SAME_OR_HIGHER = COND_CARRY_ZERO;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEM = 3'b010,
        ST_JUMP = 3'b100
    } bale_state_t;
endpackage

// ### src/bale_if.sv
/*
 * Internal carrier between the executor, its register file and its condition test.
 * Assumes all users sit on the core clock.
 */
`timescale 1ns/1ps
interface bale_if;
    logic wr_en;
    logic wr_pair;
    logic [bale_pkg::IDX_W-1:0] wr_idx;
    logic [bale_pkg::PC_W-1:0] wr_data;
    logic [bale_pkg::IDX_W-1:0] rd_idx;
    logic [bale_pkg::DATA_W-1:0] rd_data;
    logic [bale_pkg::PC_W-1:0] rd_pair;
    logic [bale_pkg::IDX_W-1:0] ptr_idx;
    logic [bale_pkg::PC_W-1:0] ptr_data;
    logic [bale_pkg::IDX_W-1:0] dbg_idx;
    logic [bale_pkg::DATA_W-1:0] dbg_data;
    bale_pkg::bale_cond_t cond;
    logic [bale_pkg::DATA_W-1:0] flags;
    logic cond_true;

    modport rf_side (input wr_en, wr_pair, wr_idx, wr_data, rd_idx, ptr_idx, dbg_idx,
                     output rd_data, rd_pair, ptr_data, dbg_data);
    modport rf_user (output wr_en, wr_pair, wr_idx, wr_data, rd_idx, ptr_idx, dbg_idx,
                     input rd_data, rd_pair, ptr_data, dbg_data);
    modport cond_side (input cond, flags, output cond_true);
    modport cond_user (output cond, flags, input cond_true);
endinterface

// ### src/bale_cond.sv
/*
 * Branch condition test on the status flag byte.
 * Assumes the flag byte is stable for the cycle in which a jump is accepted.
 */
`timescale 1ns/1ps
module bale_cond (
    // Clock and reset, used only by the checks.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Condition request and answer.
    bale_if.cond_side cnd
);
    wire logic [5:0] sources;
    wire logic [2:0] pick;
    wire logic picked;

    assign sources = {cnd.flags[bale_pkg::FLAG_V], cnd.flags[bale_pkg::FLAG_T], cnd.flags[bale_pkg::FLAG_H],
                      cnd.flags[bale_pkg::FLAG_N] ^ cnd.flags[bale_pkg::FLAG_V],
                      cnd.flags[bale_pkg::FLAG_N], cnd.flags[bale_pkg::FLAG_C]};
    assign pick = cnd.cond[3:1];
    // Unused selector codes never branch, whatever their low bit says.
    assign picked = (pick < 3'h6) ? sources[pick] ^ cnd.cond[0] : 1'b0; // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
    assign cnd.cond_true = picked; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]

    a_carry_one: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE1]
        (cnd.cond == bale_pkg::COND_LOWER) |-> (cnd.cond_true == cnd.flags[bale_pkg::FLAG_C]))
        else $error("carry one test wrong");
    a_carry_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE2]
        (cnd.cond == bale_pkg::COND_SAME_OR_HIGHER) |-> (cnd.cond_true != cnd.flags[bale_pkg::FLAG_C]))
        else $error("carry zero test wrong");
    a_negative_test: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE3]
        (cnd.cond == bale_pkg::COND_NEGATIVE) |-> (cnd.cond_true == cnd.flags[bale_pkg::FLAG_N]))
        else $error("negative test wrong");
    a_positive_test: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE4]
        (cnd.cond == bale_pkg::COND_POSITIVE) |-> (cnd.cond_true == !cnd.flags[bale_pkg::FLAG_N]))
        else $error("positive test wrong");
    a_signed_ge: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE5]
        (cnd.cond == bale_pkg::COND_SIGNED_GE) |->
        (cnd.cond_true == (cnd.flags[bale_pkg::FLAG_N] == cnd.flags[bale_pkg::FLAG_V])))
        else $error("signed ge test wrong");
    a_signed_less: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE6]
        (cnd.cond == bale_pkg::COND_SIGNED_LESS) |->
        (cnd.cond_true == (cnd.flags[bale_pkg::FLAG_N] != cnd.flags[bale_pkg::FLAG_V])))
        else $error("signed less test wrong");
    a_half_one: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE7]
        (cnd.cond == bale_pkg::COND_HALF_CARRY_ONE) |-> (cnd.cond_true == cnd.flags[bale_pkg::FLAG_H]))
        else $error("half carry one test wrong");
    a_half_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE8]
        (cnd.cond == bale_pkg::COND_HALF_CARRY_ZERO) |-> (cnd.cond_true == !cnd.flags[bale_pkg::FLAG_H]))
        else $error("half carry zero test wrong");
    a_transfer_pair: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE9]
        (cnd.cond[3:1] == bale_pkg::COND_TRANSFER_ONE[3:1]) |->
        (cnd.cond_true == (cnd.flags[bale_pkg::FLAG_T] ^ cnd.cond[0])))
        else $error("transfer test wrong");
    a_overflow_one: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE10]
        (cnd.cond == bale_pkg::COND_OVERFLOW_ONE) |-> (cnd.cond_true == cnd.flags[bale_pkg::FLAG_V]))
        else $error("overflow test wrong");
endmodule

// ### src/bale_regfile.sv
/*
 * Thirty-two byte working registers with one byte or pair write port.
 * Assumes a pair write always names an even register.
 */
`timescale 1ns/1ps
module bale_regfile (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register file access.
    bale_if.rf_side rf
);
    logic [bale_pkg::DATA_W-1:0] regs [bale_pkg::REG_CNT];

    genvar g;
    generate
        for (g = 0; g < bale_pkg::REG_CNT; g++) begin : g_reg
            wire logic hit;
            wire logic [bale_pkg::DATA_W-1:0] byte_in;
            assign hit = rf.wr_en & (rf.wr_pair ? (rf.wr_idx[bale_pkg::IDX_W-1:1] == (bale_pkg::IDX_W-1)'(g / 2))
                                                : (rf.wr_idx == bale_pkg::IDX_W'(g)));
            assign byte_in = (rf.wr_pair && (g % 2 == 1)) ? rf.wr_data[bale_pkg::PC_W-1:bale_pkg::DATA_W]
                                                          : rf.wr_data[bale_pkg::DATA_W-1:0];
            always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    regs[g] <= bale_pkg::RESET_BYTE;
                end else if (hit) begin
                    regs[g] <= byte_in;
                end
            end
        end
    endgenerate

    assign rf.rd_data = regs[rf.rd_idx];
    assign rf.rd_pair = {regs[{rf.rd_idx[bale_pkg::IDX_W-1:1], 1'b1}], regs[{rf.rd_idx[bale_pkg::IDX_W-1:1], 1'b0}]};
    assign rf.ptr_data = {regs[{rf.ptr_idx[bale_pkg::IDX_W-1:1], 1'b1}], regs[{rf.ptr_idx[bale_pkg::IDX_W-1:1], 1'b0}]};
    assign rf.dbg_data = regs[rf.dbg_idx];
endmodule

// ### src/bale_exec.sv
/*
 * Executor for conditional relative jumps, register moves and data memory loads.
 * Assumes the data memory answers a read combinationally within the cycle that
 * the read strobe is high, and writes at the edge that ends the write strobe cycle.
 */
// Overview of operation
// [RULE1] Carry one jumps to pc plus offset plus one.
// [RULE2] Carry zero jumps likewise, else continues.
// [RULE3] Negative flag one takes the relative jump.
// [RULE4] Negative flag zero takes the relative jump.
// [RULE5] Negative xor overflow zero jumps.
// [RULE6] Negative xor overflow one jumps.
// [RULE7] Half carry one jumps, flags untouched.
// [RULE8] Half carry zero jumps, flags untouched.
// [RULE9] Transfer flag one or zero jumps.
// [RULE10] Overflow one jumps, flags untouched.
// [RULE11] Copy, pair copy, constant load: one cycle.
// [RULE12] Pointer load in two cycles, optional post-increment.
// [RULE13] Pre-decrement pointer, then load from it.
// [RULE14] Y or Z plus displacement, pointer kept.
// [RULE15] Absolute address load in two cycles.
// [RULE16] Untaken jump one cycle, taken jump two.
// [RULE17] Write source byte at X, two cycles.
`timescale 1ns/1ps
module bale_exec (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Command port.
    input wire logic i_cmd_valid,
    input wire bale_pkg::bale_op_t i_cmd_op,
    input wire bale_pkg::bale_cond_t i_cmd_cond,
    input wire logic [bale_pkg::IDX_W-1:0] i_cmd_dst,
    input wire logic [bale_pkg::IDX_W-1:0] i_cmd_src,
    input wire logic [1:0] i_cmd_ptr,
    input wire logic [1:0] i_cmd_mode,
    input wire logic [bale_pkg::PC_W-1:0] i_cmd_imm,
    output logic o_cmd_ready,
    output logic o_done,
    output logic o_taken,
    // Status flags, read only.
    input wire logic [bale_pkg::DATA_W-1:0] i_flags,
    // Program counter.
    output logic [bale_pkg::PC_W-1:0] o_pc,
    // Data memory.
    output logic [bale_pkg::PC_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_wr,
    output logic [bale_pkg::DATA_W-1:0] o_mem_wdata,
    input wire logic [bale_pkg::DATA_W-1:0] i_mem_rdata,
    // Register observation.
    input wire logic [bale_pkg::IDX_W-1:0] i_dbg_idx,
    output logic [bale_pkg::DATA_W-1:0] o_dbg_data
);
    bale_if bus ();
    bale_pkg::bale_state_t state;
    bale_pkg::bale_state_t next_state;
    logic load_hold;
    logic [bale_pkg::IDX_W-1:0] dst_hold;

    bale_regfile u_regfile (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .rf(bus.rf_side)
    );

    bale_cond u_cond (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .cnd(bus.cond_side)
    );

    wire logic idle;
    wire logic accept;
    wire logic is_jump;
    wire logic is_copy;
    wire logic is_pair;
    wire logic is_const;
    wire logic is_load_ptr;
    wire logic is_load_off;
    wire logic is_load_abs;
    wire logic is_write;
    wire logic off_bad;
    wire logic mem_read;
    wire logic mem_op;
    wire logic taken;
    wire logic ptr_upd;
    wire logic [bale_pkg::IDX_W-1:0] sel_ptr_idx;
    wire logic [bale_pkg::PC_W-1:0] ptr;
    wire logic [bale_pkg::PC_W-1:0] ptr_inc;
    wire logic [bale_pkg::PC_W-1:0] ptr_dec;
    wire logic [bale_pkg::PC_W-1:0] ptr_disp;
    wire logic [bale_pkg::PC_W-1:0] k_sext;
    wire logic [bale_pkg::PC_W-1:0] jump_target;
    wire logic [bale_pkg::PC_W-1:0] next_addr;
    wire logic [bale_pkg::PC_W-1:0] next_pc;
    wire logic [bale_pkg::IDX_W-1:0] even_dst;
    wire logic next_done;

    assign idle = (state == bale_pkg::ST_IDLE);
    assign accept = i_cmd_valid & o_cmd_ready;
    assign is_jump = (i_cmd_op == bale_pkg::OP_JUMP);
    assign is_copy = (i_cmd_op == bale_pkg::OP_COPY_REGISTER);
    assign is_pair = (i_cmd_op == bale_pkg::OP_COPY_REGISTER_PAIR);
    assign is_const = (i_cmd_op == bale_pkg::OP_LOAD_CONSTANT);
    assign is_load_ptr = (i_cmd_op == bale_pkg::OP_LOAD_VIA_POINTER);
    assign is_load_off = (i_cmd_op == bale_pkg::OP_LOAD_POINTER_OFFSET);
    assign is_load_abs = (i_cmd_op == bale_pkg::OP_LOAD_ABSOLUTE);
    assign is_write = (i_cmd_op == bale_pkg::OP_WRITE_VIA_POINTER);
    // X has no displacement form; such a command retires as a one-cycle no-op.
    assign off_bad = is_load_off & (i_cmd_ptr == bale_pkg::PTR_X); // [RULE14]
    assign mem_read = is_load_ptr | (is_load_off & ~off_bad) | is_load_abs;
    assign mem_op = mem_read | is_write;

    assign bus.cond = i_cmd_cond;
    assign bus.flags = i_flags;
    assign taken = is_jump & bus.cond_true; // [RULE16]

    assign k_sext = {{(bale_pkg::PC_W-bale_pkg::K_W){i_cmd_imm[bale_pkg::K_W-1]}}, i_cmd_imm[bale_pkg::K_W-1:0]};
    assign jump_target = o_pc + k_sext + bale_pkg::PC_STEP; // [RULE1] [RULE3] [RULE7] [RULE9] [RULE10]

    // The store always goes through X, whatever the pointer field says.
    assign sel_ptr_idx = (is_write || i_cmd_ptr == bale_pkg::PTR_X) ? bale_pkg::PTR_X_LO :
                         (i_cmd_ptr == bale_pkg::PTR_Y) ? bale_pkg::PTR_Y_LO : bale_pkg::PTR_Z_LO; // [RULE17]
    assign bus.ptr_idx = sel_ptr_idx;
    assign ptr = bus.ptr_data;
    assign ptr_inc = ptr + bale_pkg::PTR_STEP;
    assign ptr_dec = ptr - bale_pkg::PTR_STEP;
    assign ptr_disp = ptr + {{(bale_pkg::PC_W-bale_pkg::Q_W){1'b0}}, i_cmd_imm[bale_pkg::Q_W-1:0]}; // [RULE14]
    assign ptr_upd = is_load_ptr & ((i_cmd_mode == bale_pkg::MODE_POSTINC) | (i_cmd_mode == bale_pkg::MODE_PREDEC));

    assign next_addr = is_load_abs ? i_cmd_imm : // [RULE15]
                       is_load_off ? ptr_disp :
                       (is_load_ptr && i_cmd_mode == bale_pkg::MODE_PREDEC) ? ptr_dec : ptr; // [RULE12] [RULE13]

    // A pair copy ignores bit zero of both register numbers.
    assign even_dst = {i_cmd_dst[bale_pkg::IDX_W-1:1], 1'b0};
    assign bus.rd_idx = is_pair ? {i_cmd_src[bale_pkg::IDX_W-1:1], 1'b0} : i_cmd_src;
    assign bus.dbg_idx = i_dbg_idx;

    // Pointer updates land at the accept edge and the loaded byte one edge later,
    // so a load whose destination is part of its own pointer keeps the loaded byte.
    assign bus.wr_en = (state == bale_pkg::ST_MEM) ? load_hold :
                       (accept & (is_copy | is_pair | is_const | ptr_upd)); // [RULE11] [RULE12]
    assign bus.wr_pair = idle & (is_pair | ptr_upd);
    assign bus.wr_idx = (state == bale_pkg::ST_MEM) ? dst_hold :
                        ptr_upd ? sel_ptr_idx : is_pair ? even_dst : i_cmd_dst;
    assign bus.wr_data = (state == bale_pkg::ST_MEM) ? {{bale_pkg::DATA_W{1'b0}}, i_mem_rdata} :
                         is_pair ? bus.rd_pair : // [RULE11]
                         ptr_upd ? ((i_cmd_mode == bale_pkg::MODE_PREDEC) ? ptr_dec : ptr_inc) : // [RULE13]
                         is_const ? {{bale_pkg::DATA_W{1'b0}}, i_cmd_imm[bale_pkg::DATA_W-1:0]} :
                         {{bale_pkg::DATA_W{1'b0}}, bus.rd_data};

    always_comb begin
        next_state = bale_pkg::ST_IDLE;
        case (state)
            bale_pkg::ST_IDLE: begin
                if (accept && taken) begin
                    next_state = bale_pkg::ST_JUMP; // [RULE16]
                end else if (accept && mem_op) begin
                    next_state = bale_pkg::ST_MEM; // [RULE12] [RULE17]
                end
            end
            bale_pkg::ST_MEM: next_state = bale_pkg::ST_IDLE;
            bale_pkg::ST_JUMP: next_state = bale_pkg::ST_IDLE;
            default: next_state = bale_pkg::ST_IDLE;
        endcase
    end

    assign next_pc = !accept ? o_pc :
                     taken ? jump_target :
                     is_load_abs ? o_pc + bale_pkg::PC_STEP_ABS : o_pc + bale_pkg::PC_STEP; // [RULE2] [RULE16]
    assign next_done = (accept & (next_state == bale_pkg::ST_IDLE)) | ~idle;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= bale_pkg::ST_IDLE;
            o_cmd_ready <= 1'b1;
            o_done <= 1'b0;
            o_taken <= 1'b0;
            o_pc <= bale_pkg::RESET_PC;
            o_mem_addr <= bale_pkg::RESET_PC;
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_wdata <= bale_pkg::RESET_BYTE;
            o_dbg_data <= bale_pkg::RESET_BYTE;
            load_hold <= 1'b0;
            dst_hold <= '0;
        end else begin
            state <= next_state;
            o_cmd_ready <= (next_state == bale_pkg::ST_IDLE);
            o_done <= next_done;
            o_taken <= (state == bale_pkg::ST_JUMP);
            o_pc <= next_pc;
            o_mem_addr <= (accept && mem_op) ? next_addr : o_mem_addr;
            o_mem_rd <= accept & mem_read;
            o_mem_wr <= accept & is_write;
            o_mem_wdata <= (accept && is_write) ? bus.rd_data : o_mem_wdata;
            o_dbg_data <= bus.dbg_data;
            load_hold <= accept & mem_read;
            dst_hold <= accept ? i_cmd_dst : dst_hold;
        end
    end

    a_taken_target: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE16]
        (accept && taken) |=> (o_pc == $past(o_pc) + $past(k_sext) + bale_pkg::PC_STEP)
        && !o_cmd_ready ##1 o_done && o_taken && o_cmd_ready)
        else $error("taken jump target or timing wrong");
    a_untaken_step: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE2]
        (accept && is_jump && !bus.cond_true) |=> (o_pc == $past(o_pc) + bale_pkg::PC_STEP)
        && o_done && !o_taken && o_cmd_ready)
        else $error("untaken jump not sequential");
    a_move_single: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE11]
        (accept && (is_copy || is_pair || is_const)) |=> o_done && o_cmd_ready && !o_mem_rd && !o_mem_wr)
        else $error("move not single cycle");
    a_pair_copy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE11]
        (accept && is_pair) |-> bus.wr_en && bus.wr_pair && (bus.wr_data == bus.rd_pair) && !bus.wr_idx[0])
        else $error("pair copy write wrong");
    a_ptr_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE12]
        (accept && is_load_ptr && i_cmd_mode != bale_pkg::MODE_PREDEC) |=>
        o_mem_rd && (o_mem_addr == $past(ptr)) && bus.wr_en && (bus.wr_idx == $past(i_cmd_dst)) ##1 o_done)
        else $error("pointer load wrong");
    a_post_inc: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE12]
        (accept && is_load_ptr && i_cmd_mode == bale_pkg::MODE_POSTINC) |->
        bus.wr_en && (bus.wr_data == ptr + bale_pkg::PTR_STEP) && (bus.wr_idx == sel_ptr_idx))
        else $error("post increment wrong");
    a_pre_dec: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE13]
        (accept && is_load_ptr && i_cmd_mode == bale_pkg::MODE_PREDEC) |=>
        o_mem_rd && (o_mem_addr == $past(ptr) - bale_pkg::PTR_STEP) && (ptr == o_mem_addr))
        else $error("pre decrement wrong");
    a_disp_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE14]
        (accept && is_load_off && !off_bad) |=> o_mem_rd && (ptr == $past(ptr))
        && (o_mem_addr == $past(ptr) + $past(i_cmd_imm[bale_pkg::Q_W-1:0])))
        else $error("displacement load wrong");
    a_abs_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE15]
        (accept && is_load_abs) |=> o_mem_rd && (o_mem_addr == $past(i_cmd_imm)) ##1 o_done && o_cmd_ready)
        else $error("absolute load wrong");
    a_store_x: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RULE17]
        (accept && is_write) |=> o_mem_wr && !o_mem_rd && (o_mem_addr == $past(ptr))
        && (o_mem_wdata == $past(bus.rd_data)) && !bus.wr_en ##1 o_done && !o_mem_wr)
        else $error("store through pointer wrong");
endmodule

// ### sim/bale_mem_model.sv
/*
 * Data memory seen by the executor's load and store commands.
 * Assumes reads are answered combinationally in the read strobe cycle.
 */
`timescale 1ns/1ps
module bale_mem_model (
    // Clock.
    input wire logic i_ref_clk,
    // Access.
    input wire logic [15:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    initial for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'h5a;
    // Outside a strobe the bus shows the inverse of the last byte, so a late capture reads wrong data.
    assign o_rdata = i_rd ? mem[i_addr[7:0]] : ~last;
    always @(posedge i_ref_clk) begin
        if (i_rd) last <= mem[i_addr[7:0]];
        if (i_wr) mem[i_addr[7:0]] <= i_wdata;
    end
endmodule

// ### sim/tb_branch_and_load_execution.sv
/*
 * Self-checking bench of the executor: jumps, moves, loads and the store.
 * Assumes the memory model holds byte a ^ 8'h5a at address a.
 */
`timescale 1ns/1ps
module tb_branch_and_load_execution;
    logic clk, rst, vld, rdy, done, taken, rd, wr;
    bale_pkg::bale_op_t op;
    bale_pkg::bale_cond_t cnd;
    logic [4:0] dst, src, dbg;
    logic [1:0] ptr, mode;
    logic [15:0] imm, pc, exp_pc, addr;
    logic [7:0] flags, rdata, wdata, dbg_data;
    int fails, comparisons;
    bale_exec u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_cmd_valid(vld), .i_cmd_op(op), .i_cmd_cond(cnd),
        .i_cmd_dst(dst), .i_cmd_src(src), .i_cmd_ptr(ptr), .i_cmd_mode(mode), .i_cmd_imm(imm),
        .o_cmd_ready(rdy), .o_done(done), .o_taken(taken), .i_flags(flags), .o_pc(pc), .o_mem_addr(addr),
        .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wdata), .i_mem_rdata(rdata), .i_dbg_idx(dbg),
        .o_dbg_data(dbg_data));
    bale_mem_model u_mem (.i_ref_clk(clk), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
        .o_rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Op codes follow the package encoding: 0 jump, 1 copy, 2 pair, 3 constant, 4 pointer, 5 offset, 6 absolute.
    task automatic issue(input logic [3:0] o, input logic [4:0] d, s, input logic [1:0] p, m,
                         input logic [15:0] i, input int ncyc, input logic [15:0] step, output logic tk);
        int n;
        @(posedge clk);
        op <= bale_pkg::bale_op_t'(o);
        dst <= d;
        src <= s;
        ptr <= p;
        mode <= m;
        imm <= i;
        vld <= 1'b1;
        #1;
        for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge clk) #1;
        check("ready", {15'h0000, rdy}, 16'h0001);
        if (n == 20) summarize();
        @(posedge clk);
        vld <= 1'b0;
        #1;
        for (n = 0; n < 4 && done !== 1'b1; n++) @(posedge clk) #1;
        tk = taken;
        exp_pc = exp_pc + step;
        check("cycles", 16'(n + 1), 16'(ncyc));
        check("pc", pc, exp_pc);
        if (n == 4) summarize();
    endtask
    task automatic setr(input logic [4:0] d, input logic [7:0] v);
        logic tk;
        issue(4'h3, d, 5'h00, 2'h0, 2'h0, {8'h00, v}, 1, 16'h0001, tk);
    endtask
    task automatic rdreg(input logic [4:0] idx, input logic [7:0] exp);
        @(posedge clk);
        dbg <= idx;
        repeat (2) @(posedge clk);
        #1;
        check("register", {8'h00, dbg_data}, {8'h00, exp});
    endtask
    task automatic t_jumps();
        logic [7:0] fl [3] = '{8'h00, 8'hff, 8'h04};
        logic [5:0] sel;
        logic [6:0] k;
        logic go, tk;
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 3; f++) begin
                sel = {fl[f][3], fl[f][6], fl[f][5], fl[f][2] ^ fl[f][3], fl[f][2], fl[f][0]};
                go = (c < 12) ? sel[c >> 1] ^ c[0] : 1'b0;
                k = (f == 1) ? 7'h7e : 7'h05;
                @(posedge clk);
                flags <= fl[f];
                cnd <= bale_pkg::bale_cond_t'(c);
                issue(4'h0, 5'h00, 5'h00, 2'h0, 2'h0, {9'h000, k}, go ? 2 : 1,
                      go ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001, tk);
                check("taken", {15'h0000, tk}, {15'h0000, go});
            end
        end
    endtask
    task automatic t_moves();
        logic tk;
        setr(5'h10, 8'ha5);
        setr(5'h11, 8'h3c);
        issue(4'h1, 5'h05, 5'h10, 2'h0, 2'h0, 16'h0000, 1, 16'h0001, tk);
        issue(4'h2, 5'h02, 5'h10, 2'h0, 2'h0, 16'h0000, 1, 16'h0001, tk);
        rdreg(5'h05, 8'ha5);
        rdreg(5'h02, 8'ha5);
        rdreg(5'h03, 8'h3c);
    endtask
    task automatic t_loads();
        logic tk;
        setr(5'h1a, 8'h10);
        setr(5'h1c, 8'hff);
        setr(5'h1f, 8'h01);
        issue(4'h4, 5'h01, 5'h00, 2'h0, 2'h0, 16'h0000, 2, 16'h0001, tk);
        rdreg(5'h01, 8'h10 ^ 8'h5a);
        rdreg(5'h1a, 8'h10);
        issue(4'h4, 5'h01, 5'h00, 2'h1, 2'h1, 16'h0000, 2, 16'h0001, tk);
        rdreg(5'h01, 8'hff ^ 8'h5a);
        rdreg(5'h1d, 8'h01);
        issue(4'h4, 5'h01, 5'h00, 2'h2, 2'h2, 16'h0000, 2, 16'h0001, tk);
        rdreg(5'h01, 8'hff ^ 8'h5a);
        rdreg(5'h1f, 8'h00);
        issue(4'h5, 5'h01, 5'h00, 2'h1, 2'h0, 16'h003f, 2, 16'h0001, tk);
        rdreg(5'h01, 8'h3f ^ 8'h5a);
        rdreg(5'h1c, 8'h00);
        issue(4'h5, 5'h04, 5'h00, 2'h0, 2'h0, 16'h0001, 1, 16'h0001, tk);
        rdreg(5'h04, 8'h00);
        issue(4'h6, 5'h01, 5'h00, 2'h0, 2'h0, 16'h00aa, 2, 16'h0002, tk);
        rdreg(5'h01, 8'haa ^ 8'h5a);
    endtask
    task automatic t_store();
        logic tk;
        issue(4'h7, 5'h00, 5'h10, 2'h0, 2'h0, 16'h0000, 2, 16'h0001, tk);
        check("store addr", addr, 16'h0010);
        check("store data", {8'h00, wdata}, 16'h00a5);
        issue(4'h6, 5'h06, 5'h00, 2'h0, 2'h0, 16'h0010, 2, 16'h0002, tk);
        rdreg(5'h06, 8'ha5);
        rdreg(5'h1a, 8'h10);
    endtask
    initial begin
        {rst, vld, dst, src, dbg, ptr, mode, imm, flags, exp_pc} = {1'b1, 60'h0};
        op = bale_pkg::OP_JUMP;
        cnd = bale_pkg::COND_CARRY_ONE;
        fails = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_jumps();
        t_moves();
        t_loads();
        t_store();
        summarize();
    end
endmodule
